// >>> pkg/logic_eval_pkg.sv
/*
  Constants for the programmable logic evaluator: register map, entry coding,
  field layouts, reset values and timing counts.
  Assumes a 100 MHz APB clock and 32-bit APB data.
*/
package logic_eval_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int ENTRY_COUNT    = 512;
  localparam int TIMER_COUNT    = 32;
  localparam int VOUT_COUNT     = 96;
  localparam int LATCH_COUNT    = 16;
  localparam int STACK_DEPTH    = 64;
  localparam int ANALOG_COUNT   = 8;
  localparam int GATE_MAX       = 16;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int POWER_CYCLE_US   = 16666;                       // 60 Hz cycle
  localparam int PASSES_PER_CYCLE = 4;
  localparam int PASS_US          = POWER_CYCLE_US / PASSES_PER_CYCLE;
  localparam int PASS_CYCLES      = PASS_US * CLK_MHZ;
  localparam int TICK_US          = 1000;                        // 1 ms timebase
  localparam int TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam int TICKS_PER_SEC    = 1000;

  // ----------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_VIN     = 12'h008;
  localparam logic [11:0] ADDR_CPOL    = 12'h00c;
  localparam logic [11:0] ADDR_ELEN    = 12'h010;
  localparam logic [11:0] ADDR_CMP_CFG = 12'h014;
  localparam logic [11:0] ADDR_CMP_THR = 12'h018;
  localparam logic [11:0] ADDR_VOUT0   = 12'h020;
  localparam logic [11:0] ADDR_VOUT1   = 12'h024;
  localparam logic [11:0] ADDR_VOUT2   = 12'h028;
  localparam logic [11:0] ADDR_TIMER   = 12'h080;                 // 32 words
  localparam logic [11:0] ADDR_EQ      = 12'h800;                 // 512 words

  // ----------------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------------
  localparam logic        RST_RUN      = 1'b1;
  localparam logic [31:0] RST_ELEN     = 32'hffffffff;
  localparam int TMR_PU_LSB  = 0;     // pickup delay [14:0]
  localparam int TMR_DO_LSB  = 15;    // dropout delay [29:15]
  localparam int TMR_UNIT    = 31;    // 0 ms, 1 s
  localparam int CMP_PLUS_LSB  = 0;   // [3:0] 0 off, 1..8 channel
  localparam int CMP_MINUS_LSB = 4;   // [7:4]
  localparam int CMP_ABS       = 8;
  localparam int CMP_DELTA     = 9;
  localparam int CMP_UNDER     = 10;
  localparam int CMP_DELTA_WINDOW_UNIT   = 11;  // 0 ms, 1 s
  localparam int CMP_DT_LSB    = 12;  // [27:12] delta window

  // ----------------------------------------------------------------------
  // Entry coding: [15:11] opcode, [10:0] argument
  // ----------------------------------------------------------------------
  localparam int OPC_LSB = 11;
  localparam logic [4:0] OPC_END  = 5'h00, OPC_ON   = 5'h01, OPC_OFF  = 5'h02;
  localparam logic [4:0] OPC_CONT = 5'h03, OPC_VIN  = 5'h04, OPC_VOUT = 5'h05;
  localparam logic [4:0] OPC_PKP  = 5'h06, OPC_OPR  = 5'h07, OPC_CMP  = 5'h08;
  localparam logic [4:0] OPC_NOT  = 5'h09, OPC_OR   = 5'h0a, OPC_AND  = 5'h0b;
  localparam logic [4:0] OPC_NOR  = 5'h0c, OPC_NAND = 5'h0d, OPC_XOR  = 5'h0e;
  localparam logic [4:0] OPC_LAT  = 5'h0f, OPC_TMR  = 5'h10, OPC_ASGN = 5'h11;

  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_EVAL} eng_state_type;
endpackage

// >>> src/logic_evaluator.sv
/*
  Programmable logic evaluator: a stack machine that walks a 512-entry
  equation store, with 32 delay timers, latches and one analog comparator.
  Assumes an APB master on pclk, element flags and analog values on pclk,
  and contact inputs arriving asynchronously from pins.
*/
// What this block does
// - 512 entries, all END after initialisation
// - Walk in order, stop at first END
// - Full pass at least four times per cycle
// - Disabled element flags always read zero
// - Forward virtual output references are accepted
// - NOT inverts the one preceding result
// - Gate input count taken from the code
// - Contact ON polarity selectable per input
// - Constant true and false operands
// - Thirty-two identical delay timers
// - Each timer selects its time unit
// - Pickup after delay, zero means immediate
// - Dropout after delay, zero means immediate
// - Comparator signal is plus minus minus
// - Plus input off reads as zero
// - Minus input subtracts, off reads zero
// - Both inputs off never asserts output
// - Mismatched input types keep comparator idle
// - Signed or absolute difference selectable
// - Level or rate-of-change over window
// - Over or under threshold direction
// - Latch: reset preceding, set before, reset wins
// - Timer driven by preceding result
// - Setting change recompiles and clears latches
// - Duplicate timer or assignment flags error
`timescale 1ns/1ps
module logic_evaluator
  import logic_eval_pkg::*;
#(
  parameter int PASS_CYCLES_P = PASS_CYCLES,
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Field inputs
  input  wire logic [31:0]   contact_pins,
  input  wire logic [31:0]   element_pickup,
  input  wire logic [31:0]   element_operate,
  input  wire logic [127:0]  analog_values,
  input  wire logic [23:0]   analog_types,
  // Results
  output logic      [95:0]   virtual_outputs,
  output logic               syntax_error,
  output logic               comparator_out
);
  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (PASS_CYCLES_P < ENTRY_COUNT + 8 || PASS_CYCLES_P > PASS_CYCLES) begin : g_bad_pass
    $error("pass period cannot hold a full pass or is too slow");
  end
  if (TICK_CYCLES_P < 2) begin : g_bad_tick
    $error("tick period too short");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    eng_state_type            st;
    logic [8:0]               pc;
    logic [6:0]               sp;
    logic [STACK_DEPTH-1:0]   stk;
    logic                     run;
    logic [31:0]              vin;
    logic [31:0]              cpol;
    logic [31:0]              elen;
    logic [27:0]              cmp_cfg;
    logic [15:0]              cmp_thr;
    logic [95:0]              vout;
    logic [LATCH_COUNT-1:0]   latch;
    logic [31:0]              tin;
    logic [31:0]              tout;
    logic [31:0][14:0]        tcnt;
    logic [31:0]              used_t;
    logic [95:0]              used_v;
    logic                     perr;
    logic                     serr;
    logic [31:0]              pass_cnt;
    logic [31:0]              tick_cnt;
    logic [9:0]               ms_cnt;
    logic [15:0]              win_cnt;
    logic signed [17:0]       cmp_ref;
    logic                     cmp_out;
    logic [31:0]              cs1;
    logic [31:0]              cs2;
    logic [31:0]              rdata;
    logic                     rerr;
  } state_type;

  state_type s;
  state_type next_s;

  // Equation store and timer settings
  logic [15:0] eq_mem [ENTRY_COUNT];
  logic [31:0] tcfg   [TIMER_COUNT];

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Address decode shared by read and write paths
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a[1:0] == 2'b00) &&
              (a[11] || (a[11:7] == ADDR_TIMER[11:7]) || (a <= ADDR_VOUT2 && a != 12'h01c));
  endfunction

  function automatic logic is_setting(input logic [11:0] a);
    is_setting = a[11] || a[11:7] == ADDR_TIMER[11:7] || a == ADDR_CTRL || a == ADDR_CPOL ||
                 a == ADDR_ELEN || a == ADDR_CMP_CFG || a == ADDR_CMP_THR;
  endfunction

  // Channel select: 0 or above range means off
  function automatic logic ch_on(input logic [3:0] sel);
    ch_on = (sel != 4'h0) && (sel <= 4'(ANALOG_COUNT));
  endfunction

  function automatic logic [2:0] ch_idx(input logic [3:0] sel);
    ch_idx = 3'(sel - 4'h1);
  endfunction

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready          = 1'b1;
  assign prdata          = s.rdata;
  assign pslverr         = s.rerr;
  assign virtual_outputs = s.vout;
  assign syntax_error    = s.serr;
  assign comparator_out  = s.cmp_out;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  logic                 ms_tick;
  logic                 sec_tick;
  logic                 t_tick;
  logic [14:0]          dly;
  logic                 p_on;
  logic                 m_on;
  logic signed [17:0]   p_val;
  logic signed [17:0]   m_val;
  logic signed [17:0]   diff;
  logic signed [17:0]   mag;
  logic signed [18:0]   op_sig;
  logic signed [18:0]   thr;
  logic                 cmp_valid;
  logic [15:0]          win;
  logic [15:0]          code;
  logic [4:0]           opc;
  logic [10:0]          arg;
  logic [GATE_MAX-1:0]  a;
  logic [GATE_MAX-1:0]  gm;
  logic [4:0]           gcnt;
  logic [4:0]           popn;
  logic [6:0]           nsp;
  logic                 dopush;
  logic                 pushv;
  logic                 fin;
  logic                 wr_acc;
  logic                 setup;

  always_comb begin
    next_s = s;
    // Contact pins through two flops
    next_s.cs1 = contact_pins;
    next_s.cs2 = s.cs1;

    // Millisecond and second ticks
    ms_tick  = (s.tick_cnt == 32'(TICK_CYCLES_P - 1));
    sec_tick = ms_tick && (s.ms_cnt == 10'(TICKS_PER_SEC - 1));
    next_s.tick_cnt = ms_tick ? 32'h0 : s.tick_cnt + 32'h1;
    if (ms_tick) begin
      next_s.ms_cnt = sec_tick ? 10'h0 : s.ms_cnt + 10'h1;
    end

    // Timers run between evaluations on their own unit
    for (int k = 0; k < TIMER_COUNT; k++) begin
      t_tick = tcfg[k][TMR_UNIT] ? sec_tick : ms_tick;
      dly    = s.tin[k] ? tcfg[k][TMR_PU_LSB +: 15] : tcfg[k][TMR_DO_LSB +: 15];
      if (s.tin[k] == s.tout[k]) begin
        next_s.tcnt[k] = 15'h0;
      end else if (t_tick) begin
        if (s.tcnt[k] + 15'h1 >= dly) begin
          next_s.tout[k] = s.tin[k];
          next_s.tcnt[k] = 15'h0;
        end else begin
          next_s.tcnt[k] = s.tcnt[k] + 15'h1;
        end
      end
    end

    // Comparator operating signal
    p_on  = ch_on(s.cmp_cfg[CMP_PLUS_LSB +: 4]);
    m_on  = ch_on(s.cmp_cfg[CMP_MINUS_LSB +: 4]);
    p_val = p_on ? 18'(signed'(analog_values[16*ch_idx(s.cmp_cfg[3:0]) +: 16])) : 18'sh0;
    m_val = m_on ? 18'(signed'(analog_values[16*ch_idx(s.cmp_cfg[7:4]) +: 16])) : 18'sh0;
    diff  = p_val - m_val;
    mag   = (s.cmp_cfg[CMP_ABS] && diff < 0) ? -diff : diff;
    op_sig = s.cmp_cfg[CMP_DELTA] ? 19'(mag) - 19'(s.cmp_ref) : 19'(mag);
    thr    = 19'(signed'(s.cmp_thr));
    cmp_valid = (p_on || m_on) &&
                !(p_on && m_on && analog_types[3*ch_idx(s.cmp_cfg[3:0]) +: 3] !=
                  analog_types[3*ch_idx(s.cmp_cfg[7:4]) +: 3]);
    next_s.cmp_out = cmp_valid && (s.cmp_cfg[CMP_UNDER] ? (op_sig < thr) : (op_sig > thr));

    // Delta window sampling of the reference
    win = (s.cmp_cfg[CMP_DT_LSB +: 16] == 16'h0) ? 16'h1 : s.cmp_cfg[CMP_DT_LSB +: 16];
    if (s.cmp_cfg[CMP_DELTA_WINDOW_UNIT] ? sec_tick : ms_tick) begin
      if (s.win_cnt + 16'h1 >= win) begin
        next_s.win_cnt = 16'h0;
        next_s.cmp_ref = mag;
      end else begin
        next_s.win_cnt = s.win_cnt + 16'h1;
      end
    end

    // Pass scheduler
    next_s.pass_cnt = (s.pass_cnt == 32'(PASS_CYCLES_P - 1)) ? 32'h0 : s.pass_cnt + 32'h1;

    // Stack window: a[0] is the most recent result
    for (int i = 0; i < GATE_MAX; i++) begin
      a[i] = (7'(i) < s.sp) ? s.stk[6'(s.sp - 7'd1 - 7'(i))] : 1'b0;
    end
    code   = eq_mem[s.pc];
    opc    = code[OPC_LSB +: 5];
    arg    = code[10:0];
    gcnt   = (arg < 11'd2) ? 5'd2 : (arg > 11'(GATE_MAX)) ? 5'(GATE_MAX) : arg[4:0];
    for (int i = 0; i < GATE_MAX; i++) begin
      gm[i] = 5'(i) < gcnt;
    end
    popn   = 5'd0;
    dopush = 1'b0;
    pushv  = 1'b0;
    fin    = 1'b0;

    unique case (s.st)
      ST_INIT: begin
        // Store is filled with END, one entry per cycle
        next_s.pc = s.pc + 9'h1;
        if (s.pc == 9'(ENTRY_COUNT - 1)) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (s.run && s.pass_cnt == 32'h0) begin
          next_s.st     = ST_EVAL;
          next_s.pc     = 9'h0;
          next_s.sp     = 7'h0;
          next_s.used_t = 32'h0;
          next_s.used_v = 96'h0;
          next_s.perr   = 1'b0;
        end
      end
      ST_EVAL: begin
        dopush = 1'b1;
        case (opc)
          OPC_END:  begin
            dopush = 1'b0;
            fin    = 1'b1;
          end
          OPC_ON:   pushv = 1'b1;
          OPC_OFF:  pushv = 1'b0;
          OPC_CONT: pushv = s.cs2[arg[4:0]] ^ s.cpol[arg[4:0]];
          OPC_VIN:  pushv = s.vin[arg[4:0]];
          OPC_VOUT: pushv = (arg < 11'(VOUT_COUNT)) && s.vout[7'(arg)];
          OPC_PKP:  pushv = element_pickup[arg[4:0]] & s.elen[arg[4:0]];
          OPC_OPR:  pushv = element_operate[arg[4:0]] & s.elen[arg[4:0]];
          OPC_CMP:  pushv = s.cmp_out;
          OPC_NOT:  begin
            popn  = 5'd1;
            pushv = ~a[0];
          end
          OPC_OR, OPC_AND, OPC_NOR, OPC_NAND, OPC_XOR: begin
            popn = gcnt;
            unique case (opc)
              OPC_OR:   pushv = |(a & gm);
              OPC_AND:  pushv = &(a | ~gm);
              OPC_NOR:  pushv = ~|(a & gm);
              OPC_NAND: pushv = ~&(a | ~gm);
              default:  pushv = ^(a & gm);
            endcase
          end
          OPC_LAT:  begin
            popn = 5'd2;
            if (a[0]) begin
              next_s.latch[arg[3:0]] = 1'b0;
            end else if (a[1]) begin
              next_s.latch[arg[3:0]] = 1'b1;
            end
            pushv = next_s.latch[arg[3:0]];
          end
          OPC_TMR:  begin
            popn = 5'd1;
            if (s.used_t[arg[4:0]]) begin
              next_s.perr = 1'b1;
            end
            next_s.used_t[arg[4:0]] = 1'b1;
            if (a[0] != s.tin[arg[4:0]]) begin
              next_s.tin[arg[4:0]]  = a[0];
              next_s.tcnt[arg[4:0]] = 15'h0;
              dly = a[0] ? tcfg[arg[4:0]][TMR_PU_LSB +: 15] : tcfg[arg[4:0]][TMR_DO_LSB +: 15];
              if (dly == 15'h0) begin
                next_s.tout[arg[4:0]] = a[0];
              end
            end
            pushv = next_s.tout[arg[4:0]];
          end
          OPC_ASGN: begin
            dopush = 1'b0;
            popn   = 5'd1;
            if (arg < 11'(VOUT_COUNT)) begin
              if (s.used_v[7'(arg)]) begin
                next_s.perr = 1'b1;
              end
              next_s.used_v[7'(arg)] = 1'b1;
              next_s.vout[7'(arg)]   = a[0];
            end
          end
          default:  pushv = 1'b0;
        endcase
        // Pop then push, saturating at both ends of the stack
        nsp = (7'(popn) > s.sp) ? 7'h0 : s.sp - 7'(popn);
        if (opc == OPC_ASGN) begin
          nsp = 7'h0;
        end
        if (dopush && nsp < 7'(STACK_DEPTH)) begin
          next_s.stk[6'(nsp)] = pushv;
          nsp = nsp + 7'h1;
        end
        next_s.sp = nsp;
        next_s.pc = s.pc + 9'h1;
        if (fin || s.pc == 9'(ENTRY_COUNT - 1)) begin
          next_s.st   = ST_IDLE;
          next_s.serr = next_s.perr;
        end
      end
    endcase

    // APB read data and error, prepared in the setup cycle
    setup = psel && !penable;
    if (setup) begin
      next_s.rerr  = !addr_ok(paddr) || (paddr[11] && s.st == ST_INIT);
      next_s.rdata = 32'h0;
      if (!next_s.rerr && !pwrite) begin
        if (paddr[11]) begin
          next_s.rdata = {16'h0, eq_mem[paddr[10:2]]};
        end else if (paddr[11:7] == ADDR_TIMER[11:7]) begin
          next_s.rdata = tcfg[paddr[6:2]];
        end else begin
          unique case (paddr)
            ADDR_CTRL:    next_s.rdata = {31'h0, s.run};
            ADDR_STATUS:  next_s.rdata = {29'h0, s.cmp_out, s.st != ST_IDLE, s.serr};
            ADDR_VIN:     next_s.rdata = s.vin;
            ADDR_CPOL:    next_s.rdata = s.cpol;
            ADDR_ELEN:    next_s.rdata = s.elen;
            ADDR_CMP_CFG: next_s.rdata = {4'h0, s.cmp_cfg};
            ADDR_CMP_THR: next_s.rdata = {16'h0, s.cmp_thr};
            ADDR_VOUT0:   next_s.rdata = s.vout[31:0];
            ADDR_VOUT1:   next_s.rdata = s.vout[63:32];
            ADDR_VOUT2:   next_s.rdata = s.vout[95:64];
            default:      next_s.rdata = 32'h0;
          endcase
        end
      end
    end

    // APB writes take effect in the access cycle
    wr_acc = psel && penable && pwrite && !s.rerr;
    if (wr_acc) begin
      unique case (paddr)
        ADDR_CTRL:    next_s.run     = pwdata[0];
        ADDR_VIN:     next_s.vin     = pwdata;
        ADDR_CPOL:    next_s.cpol    = pwdata;
        ADDR_ELEN:    next_s.elen    = pwdata;
        ADDR_CMP_CFG: next_s.cmp_cfg = pwdata[27:0];
        ADDR_CMP_THR: next_s.cmp_thr = pwdata[15:0];
        default:      next_s.run     = next_s.run;
      endcase
      if (is_setting(paddr)) begin
        // Recompile: drop the pass, clear latches, rerun at once
        next_s.latch    = '0;
        next_s.pass_cnt = 32'h0;
        next_s.perr     = 1'b0;
        if (s.st == ST_EVAL) begin
          next_s.st = ST_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.st    <= ST_INIT;
      s.run   <= RST_RUN;
      s.elen  <= RST_ELEN;
      s.latch <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Equation store and timer settings
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (s.st == ST_INIT) begin
      eq_mem[s.pc] <= {OPC_END, 11'h0};
    end else if (psel && penable && pwrite && !s.rerr && paddr[11]) begin
      eq_mem[paddr[10:2]] <= pwdata[15:0];
    end
    if (psel && penable && pwrite && !s.rerr && paddr[11:7] == ADDR_TIMER[11:7]) begin
      tcfg[paddr[6:2]] <= pwdata;
    end
  end
endmodule

// >>> test/field_model.sv
/* Field side: contact pins, element flags and analog channels.
   Assumes the bench changes the scene well between passes. */
`timescale 1ns/1ps
module field_model (
  // Scene from the bench
  input  wire logic         pclk,
  input  wire logic [31:0]  closed,
  input  wire logic [31:0]  op_set,
  // Field side
  output logic      [31:0]  contact_pins,
  output logic      [31:0]  element_pickup,
  output logic      [31:0]  element_operate,
  output logic      [127:0] analog_values,
  output logic      [23:0]  analog_types
);
  // Pins and operate flags follow the scene one clock later, pickup flags at once
  always_ff @(posedge pclk) begin
    contact_pins <= closed;
    element_operate <= op_set;
  end
  // Every channel reads 200, each of its own type
  assign element_pickup = op_set;
  assign analog_values = {8{16'h00c8}};
  assign analog_types = 24'hfac688;
endmodule

// >>> test/logic_eval_props.sv
/* Port checker for the logic evaluator.
   Assumes an APB master that keeps the setup and access order. */
`timescale 1ns/1ps
module logic_eval_props
  import logic_eval_pkg::*;
(
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Results
  input wire logic [95:0] virtual_outputs,
  input wire logic        syntax_error,
  input wire logic        comparator_out
);
  logic [9:0] since_rst;
  wire        setup = psel && !penable;
  // Cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_rst <= 10'h0;
    else if (since_rst != 10'h3ff) since_rst <= since_rst + 10'h1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_unmapped_err: assert property (setup && paddr == 12'h01c |=> pslverr)
    else $error("unmapped read without error");
  chk_misaligned_err: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == '0)
    else $error("misaligned read without error");
  chk_ctrl_clean: assert property (setup && paddr == ADDR_CTRL |=> !pslverr && prdata[31:1] == '0)
    else $error("control read wrong");
  chk_vout_read: assert property (setup && paddr == ADDR_VOUT0 |=>
    prdata == $past(virtual_outputs[31:0])) else $error("output word wrong");
  chk_status_bits: assert property (setup && paddr == ADDR_STATUS |=>
    prdata[0] == $past(syntax_error) && prdata[2] == $past(comparator_out))
    else $error("status word wrong");
  chk_init_refuse: assert property (setup && paddr[11] && since_rst < 10'd500 |=> pslverr)
    else $error("store open during init");
  chk_init_quiet: assert property (since_rst < 10'd500 |-> virtual_outputs == '0)
    else $error("outputs set during init");
endmodule
bind logic_evaluator logic_eval_props chk_u (.pclk, .presetn, .paddr, .psel, .penable,
  .prdata, .pready, .pslverr, .virtual_outputs, .syntax_error, .comparator_out);

// >>> test/testbench.sv
/* Bench: APB tasks, equation runs and comparator settings.
   Assumes the package, design, model and checker are compiled first. */
`timescale 1ns/1ps
module testbench
  import logic_eval_pkg::*;
;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, closed = 32'h0;
  logic [31:0]  rdata, prdata, contact_pins, element_pickup, element_operate;
  logic [127:0] analog_values;
  logic [95:0]  virtual_outputs;
  logic [23:0]  analog_types;
  logic         rerr, pready, pslverr, syntax_error, comparator_out;
  logic [15:0]  prog [10] = '{{OPC_OPR, 11'h2}, {OPC_CONT, 11'h0}, {OPC_NOT, 11'h0},
    {OPC_AND, 11'h2}, {OPC_ASGN, 11'h3}, {OPC_ON, 11'h0}, {OPC_ASGN, 11'h5},
    {OPC_END, 11'h0}, {OPC_ON, 11'h0}, {OPC_ASGN, 11'h4}};
  logic [31:0]  cfg [6] = '{32'h001, 32'h401, 32'h400, 32'h031, 32'h410, 32'h510};
  logic [5:0]   cres = 6'h11;
  // Latch and timer program: set, reset, latch, assign 0, timer input, timer, assign 1
  logic [15:0]  prog2 [8] = '{{OPC_VIN, 11'h0}, {OPC_VIN, 11'h1}, {OPC_LAT, 11'h0},
    {OPC_ASGN, 11'h0}, {OPC_VIN, 11'h2}, {OPC_TMR, 11'h0}, {OPC_ASGN, 11'h1}, {OPC_END, 11'h0}};
  logic [2:0]   vseq [4] = '{3'h5, 3'h3, 3'h1, 3'h0};
  logic [1:0]   vres [4] = '{2'h3, 2'h0, 2'h1, 2'h1};
  int           errors = 0;
  int           cmp_count = 0;
  always #5 pclk = ~pclk;
  logic_evaluator #(.PASS_CYCLES_P(600), .TICK_CYCLES_P(10)) dut_u (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .contact_pins,
    .element_pickup, .element_operate, .analog_values, .analog_types, .virtual_outputs,
    .syntax_error, .comparator_out);
  field_model model_u (.pclk, .closed, .op_set(32'h4), .contact_pins, .element_pickup,
    .element_operate, .analog_values, .analog_types);
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) begin
      errors++;
      tally_and_finish();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, m, input logic er);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
    chk({31'h0, rerr}, {31'h0, er});
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_ELEN, RST_ELEN, '1, 1'b0);
    rd(ADDR_EQ, 32'h0, '1, 1'b1);
    rd(12'h01c, 32'h0, '1, 1'b1);
    rd(12'h002, 32'h0, '1, 1'b1);
    rd(ADDR_CTRL, 32'h1, '1, 1'b0);
    repeat (520) @(posedge pclk);
    rd(ADDR_EQ + 12'h7fc, 32'h0, '1, 1'b0);
    for (int i = 0; i < 10; i++) apb(1'b1, ADDR_EQ + 12'(4 * i), {16'h0, prog[i]});
    for (int s = 0; s < 4; s++) begin
      closed <= {31'h0, s != 0};
      apb(1'b1, ADDR_CPOL, {31'h0, s >= 2});
      apb(1'b1, ADDR_ELEN, s == 3 ? 32'hfffffffb : '1);
      repeat (1250) @(posedge pclk);
      rd(ADDR_VOUT0, s[0] ? 32'h20 : 32'h28, '1, 1'b0);
    end
    apb(1'b1, ADDR_EQ + 12'h1c, {16'h0, OPC_ASGN, 11'h3});
    repeat (1250) @(posedge pclk);
    rd(ADDR_STATUS, 32'h1, 32'h1, 1'b0);
    rd(ADDR_VOUT0, 32'h30, '1, 1'b0);
    apb(1'b1, ADDR_CMP_THR, 32'h64);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ADDR_CMP_CFG, cfg[i]);
      repeat (4) @(posedge pclk);
      rd(ADDR_STATUS, {29'h0, cres[i], 2'h0}, 32'h4, 1'b0);
    end
    // Timer 0: pickup 3 ms, dropout 0, then latch and timer program
    apb(1'b1, ADDR_TIMER, 32'h3);
    for (int i = 0; i < 8; i++) apb(1'b1, ADDR_EQ + 12'(4 * i), {16'h0, prog2[i]});
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ADDR_VIN, {29'h0, vseq[s]});
      repeat (1250) @(posedge pclk);
      rd(ADDR_VOUT0, {30'h0, vres[s]}, 32'h3, 1'b0);
    end
    tally_and_finish();
  end
endmodule
